// >>> dv/prxec_checker.sv
// Assertion checker for the receive error code and bypass block
`timescale 1ns/10ps
module prxec_checker
    import prxec_pkg::*;
(
    input wire logic             ref_clk,
    input wire logic             srst,
    input wire logic [4:0]       reg_addr,
    input wire logic [15:0]      reg_wdata,
    input wire logic             reg_wr,
    input wire logic             reg_rd,
    input wire logic [15:0]      reg_rdata,
    input wire logic             sym_mode_strap,
    input wire logic             repeater_select_strap,
    input wire logic [1:0]       indicator_route_mode,
    input wire logic             rx_sym_valid,
    input wire logic [4:0]       rx_sym,
    input wire logic             link_fail,
    input wire logic             unstable_link_detect,
    input wire logic [4:0]       tx_in,
    input wire logic [4:0]       tx_sym_out,
    input wire logic             transmit_indicator_output,
    input wire prxec_mii_rx_type mii_rx
);
    logic [3:0] sel_ff, nxt_sel;   // Shadow of the error select bits
    logic       mdis_ff, nxt_mdis; // Shadow of the monitor disable bit
    logic       byp_ff, nxt_byp;   // Shadow of the nibble bypass bit
    logic       pcs_wr, lb_wr, pcs_rd, lb_rd, map_rd, route_ab;
    assign pcs_wr   = reg_wr && reg_addr == PRXEC_PCS_CFG_ADDR;
    assign lb_wr    = reg_wr && reg_addr == PRXEC_LB_BYP_ADDR;
    assign pcs_rd   = reg_rd && reg_addr == PRXEC_PCS_CFG_ADDR;
    assign lb_rd    = reg_rd && reg_addr == PRXEC_LB_BYP_ADDR;
    assign map_rd   = reg_rd && reg_addr inside {5'h16, 5'h17, 5'h1a, 5'h1b};
    assign route_ab = indicator_route_mode inside {PRXEC_ROUTE_MODE_A, PRXEC_ROUTE_MODE_B};
    // Straps load on every clock edge while reset is held, software may overwrite later
    always_comb begin
        nxt_sel  = srst ? PRXEC_SEL_RST : (pcs_wr ? reg_wdata[3:0] : sel_ff);
        nxt_mdis = srst ? ~repeater_select_strap : (pcs_wr ? reg_wdata[PRXEC_MON_DIS_BIT] : mdis_ff);
        nxt_byp  = srst ? sym_mode_strap : (lb_wr ? reg_wdata[PRXEC_NIB_BYP_BIT] : byp_ff);
    end
    // Registers only
    always_ff @(posedge ref_clk) begin
        sel_ff  <= nxt_sel;
        mdis_ff <= nxt_mdis;
        byp_ff  <= nxt_byp;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    // Routed flag must show after it has been steady a few cycles
    sequence flag_held;
        (route_ab && unstable_link_detect && !mdis_ff)[*3];
    endsequence
    rdata_idle_a: assert property (!$past(map_rd) |-> reg_rdata == 16'h0000)
        else $error("read data not zero");
    pcs_read_a: assert property ($past(pcs_rd) |->
        reg_rdata[15:6] == 10'h000 && reg_rdata[5] == mdis_ff && reg_rdata[3:0] == sel_ff)
        else $error("pcs read mismatch");
    lb_read_a: assert property ($past(lb_rd) |->
        !reg_rdata[15] && reg_rdata[13] == byp_ff && reg_rdata[12:0] == 13'h0000)
        else $error("loopback read mismatch");
    link_err_a: assert property (link_fail && sel_ff[PRXEC_LINK_SEL_BIT] |=>
        mii_rx.er && mii_rx.rxd == PRXEC_NIB_LINK) else $error("link error not reported");
    link_pass_a: assert property (link_fail && !sel_ff[PRXEC_LINK_SEL_BIT] && !rx_sym_valid |=>
        !mii_rx.er) else $error("link error flagged while off");
    byp_rx_a: assert property (byp_ff && rx_sym_valid && !link_fail |=>
        mii_rx.dv && {mii_rx.er, mii_rx.rxd} == $past(rx_sym)) else $error("bypass receive mismatch");
    byp_tx_a: assert property (byp_ff |=> tx_sym_out == $past(tx_in))
        else $error("bypass transmit mismatch");
    route_led_a: assert property (flag_held |=> transmit_indicator_output)
        else $error("flag not routed to led");
endmodule : prxec_checker

// >>> dv/prxec_mac_model.sv
// Receiving controller model on the media independent receive side
`timescale 1ns/10ps
module prxec_mac_model
    import prxec_pkg::*;
(
    input wire logic             ref_clk,
    input wire logic             srst,
    input wire prxec_mii_rx_type mii_rx,
    output int                   nib_seen,
    output int                   bad_seen
);
    // Counts nibbles taken and nibbles flagged in error
    always @(posedge ref_clk) begin
        if (srst) begin
            nib_seen <= 0;
            bad_seen <= 0;
        end else begin
            nib_seen <= nib_seen + int'(mii_rx.dv);
            bad_seen <= bad_seen + int'(mii_rx.er);
        end
    end
endmodule : prxec_mac_model

// >>> dv/prxec_top_tb.sv
// Self-checking testbench for the receive error code and bypass block
`timescale 1ns/10ps
module prxec_top_tb;
    import prxec_pkg::*;
    localparam logic [4:0] PCS = PRXEC_PCS_CFG_ADDR;
    localparam logic [4:0] LB  = PRXEC_LB_BYP_ADDR;
    localparam logic [4:0] IDL = PRXEC_SYM_IDLE;
    logic             ref_clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rx_sym_valid = 1'b0;
    logic [4:0]       reg_addr = 5'h00, rx_sym = 5'h1f, tx_in = 5'h00, tx_sym_out;
    logic [15:0]      reg_wdata = 16'h0000, reg_rdata;
    logic             sym_mode_strap = 1'b1, repeater_select_strap = 1'b1, link_fail = 1'b0;
    logic             unstable_link_detect = 1'b0, tx_activity = 1'b0, rx_activity = 1'b0;
    logic [1:0]       indicator_route_mode = 2'b00;
    logic             irq, transmit_indicator_output, receive_indicator_output;
    prxec_mii_rx_type mii_rx;
    int               err_count = 0, tests_run = 0, nib_seen, bad_seen, b, n;
    // Short counts keep the run brief
    prxec_top #(.PKT_TO_CYC(8), .LED_STRETCH_CYC(4)) dut (.*);
    prxec_mac_model mac (.ref_clk, .srst, .mii_rx, .nib_seen, .bad_seen);
    initial forever #5 ref_clk = ~ref_clk;
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop
    // One-cycle register strobes
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [4:0] a, input logic [15:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        check(reg_rdata, exp);
    endtask : rd
    // Group stream; output of a group shows after the next put
    task automatic put(input logic [4:0] s);
        @(posedge ref_clk);
        rx_sym_valid <= 1'b1; rx_sym <= s;
    endtask : put
    task automatic see(input logic er, input logic [3:0] d);
        @(negedge ref_clk);
        check({11'h000, mii_rx.er, mii_rx.rxd}, {11'h000, er, d});
    endtask : see
    task automatic stop_frame();
        put(PRXEC_SYM_T); put(PRXEC_SYM_R);
        @(posedge ref_clk);
        rx_sym_valid <= 1'b0;
        repeat (2) @(posedge ref_clk);
    endtask : stop_frame
    task automatic t_regs();
        rd(PCS, 16'h0000);
        rd(LB, 16'h2000);
        rd(5'h00, 16'h0000);
        wr(LB, 16'hffff);
        rd(LB, 16'h6000);
        wr(LB, 16'h0000);
        rd(LB, 16'h0000);
    endtask : t_regs
    task automatic t_code();
        b = bad_seen;
        n = nib_seen;
        for (int s = 0; s < 2; s++) begin
            wr(PCS, 16'(s) << 3);
            put(PRXEC_SYM_J); put(PRXEC_SYM_K); put(5'h00); put(5'h1e);
            see(1'b1, s ? PRXEC_NIB_CODE_ALT : PRXEC_NIB_ERR_DEF);
            stop_frame();
        end
        check(16'(bad_seen - b), 16'h0002);
        check(16'(nib_seen - n), 16'h0004);
        rd(PRXEC_IRQ_STAT_ADDR, 16'h0001);
        check({15'h0, irq}, 16'h0000);
        wr(PRXEC_IRQ_MASK_ADDR, 16'h0001);
        @(negedge ref_clk) check({15'h0, irq}, 16'h0001);
        wr(PRXEC_IRQ_STAT_ADDR, 16'h0001);
        @(negedge ref_clk) check({15'h0, irq}, 16'h0000);
        wr(PRXEC_IRQ_MASK_ADDR, 16'h0000);
    endtask : t_code
    task automatic t_pme();
        for (int s = 0; s < 2; s++) begin
            wr(PCS, 16'(s) << 2);
            put(PRXEC_SYM_J); put(PRXEC_SYM_K); put(IDL); put(5'h1e);
            see(1'b0, 4'h0);
            put(IDL); put(IDL); put(5'h1e);
            see(1'b1, s ? PRXEC_NIB_PME_ALT : PRXEC_NIB_ERR_DEF);
            stop_frame();
        end
    endtask : t_pme
    task automatic t_link();
        wr(PCS, 16'h0002);
        @(posedge ref_clk) link_fail <= 1'b1;
        @(posedge ref_clk);
        see(1'b1, PRXEC_NIB_LINK);
        wr(PCS, 16'h0000);
        @(posedge ref_clk);
        @(negedge ref_clk) check({15'h0, mii_rx.er}, 16'h0000);
        @(posedge ref_clk) link_fail <= 1'b0;
    endtask : t_link
    task automatic t_pkt();
        for (int s = 0; s < 2; s++) begin
            wr(PCS, 16'(s));
            put(PRXEC_SYM_J); put(PRXEC_SYM_K);
            repeat (13) put(5'h1e);
            put(5'h1e);
            see(1'(s), s ? PRXEC_NIB_PKT : 4'h0);
            stop_frame();
        end
        wr(PCS, 16'h0000);
    endtask : t_pkt
    task automatic t_byp();
        wr(LB, 16'h2000);
        put(5'h1a);
        tx_in <= 5'h0c;
        put(5'h05);
        see(1'b1, 4'ha);
        check({11'h0, tx_sym_out}, 16'h000c);
        @(posedge ref_clk) rx_sym_valid <= 1'b0;
        wr(LB, 16'h0000);
        @(posedge ref_clk);
        @(negedge ref_clk) check({11'h0, tx_sym_out}, 16'h001f);
        @(posedge ref_clk) tx_in <= 5'h15;
        @(posedge ref_clk);
        @(negedge ref_clk) check({11'h0, tx_sym_out}, 16'h000b);
        @(posedge ref_clk) tx_in <= 5'h00;
    endtask : t_byp
    task automatic t_led();
        for (int s = 0; s < 2; s++) begin
            wr(LB, 16'(s) << 14);
            @(posedge ref_clk) rx_activity <= 1'b1;
            @(posedge ref_clk) rx_activity <= 1'b0;
            repeat (3) @(negedge ref_clk);
            check({15'h0, receive_indicator_output}, 16'(1 - s));
            repeat (2) @(negedge ref_clk);
            check({15'h0, receive_indicator_output}, 16'(1 - s));
            @(negedge ref_clk) check({15'h0, receive_indicator_output}, 16'h0000);
        end
        @(posedge ref_clk) unstable_link_detect <= 1'b1;
        for (int m = 1; m < 3; m++) begin
            @(posedge ref_clk) indicator_route_mode <= 2'(m);
            repeat (5) @(negedge ref_clk);
            check({15'h0, transmit_indicator_output}, 16'h0001);
        end
        rd(PCS, 16'h0010);
        @(posedge ref_clk) indicator_route_mode <= 2'b00;
        repeat (4) @(negedge ref_clk);
        check({15'h0, transmit_indicator_output}, 16'h0000);
        @(posedge ref_clk) unstable_link_detect <= 1'b0;
    endtask : t_led
    // Mid-run reset with both straps flipped
    task automatic t_rst();
        @(posedge ref_clk);
        srst <= 1'b1;
        repeater_select_strap <= 1'b0;
        sym_mode_strap <= 1'b0;
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        rd(PCS, 16'h0020);
        rd(LB, 16'h0000);
    endtask : t_rst
    initial begin
        repeat (5) @(posedge ref_clk);
        srst <= 1'b0;
        t_regs();
        t_code();
        t_pme();
        t_link();
        t_pkt();
        t_byp();
        t_led();
        t_rst();
        report_and_stop();
    end
    // Hang guard
    initial begin
        #200000;
        err_count++;
        report_and_stop();
    end
endmodule : prxec_top_tb

bind prxec_top prxec_checker chk (.*);

// >>> rtl/prxec_pkg.sv
// Package of constants and types for the receive error code and bypass config block
package prxec_pkg;
    // Register addresses on the management port
    localparam logic [4:0] PRXEC_PCS_CFG_ADDR   = 5'h16;
    localparam logic [4:0] PRXEC_LB_BYP_ADDR    = 5'h17;
    localparam logic [4:0] PRXEC_IRQ_STAT_ADDR  = 5'h1a;
    localparam logic [4:0] PRXEC_IRQ_MASK_ADDR  = 5'h1b;

    // Field positions in the pcs configuration and status register
    localparam int PRXEC_PKT_SEL_BIT    = 0;
    localparam int PRXEC_LINK_SEL_BIT   = 1;
    localparam int PRXEC_PME_SEL_BIT    = 2;
    localparam int PRXEC_CODE_SEL_BIT   = 3;
    localparam int PRXEC_UNSTABLE_BIT   = 4;
    localparam int PRXEC_MON_DIS_BIT    = 5;

    // Field positions in the loopback and bypass register
    localparam int PRXEC_NIB_BYP_BIT    = 13;
    localparam int PRXEC_STRETCH_BYP_BIT = 14;
    localparam int PRXEC_LB_RSVD_BIT    = 15;

    // Interrupt status and mask bit positions
    localparam int PRXEC_IRQ_CODE_BIT   = 0;
    localparam int PRXEC_IRQ_PME_BIT    = 1;
    localparam int PRXEC_IRQ_LINK_BIT   = 2;
    localparam int PRXEC_IRQ_PKT_BIT    = 3;
    localparam int PRXEC_IRQ_UNST_BIT   = 4;

    // Reset values
    localparam logic [3:0] PRXEC_SEL_RST         = 4'h0;
    localparam logic       PRXEC_STRETCH_BYP_RST = 1'b0;
    localparam logic [4:0] PRXEC_IRQ_RST         = 5'h00;
    localparam logic [15:0] PRXEC_RDATA_RST      = 16'h0000;

    // Substitute nibbles on receive errors
    localparam logic [3:0] PRXEC_NIB_CODE_ALT = 4'h5;
    localparam logic [3:0] PRXEC_NIB_PME_ALT  = 4'h4;
    localparam logic [3:0] PRXEC_NIB_ERR_DEF  = 4'h6;
    localparam logic [3:0] PRXEC_NIB_LINK     = 4'h3;
    localparam logic [3:0] PRXEC_NIB_PKT      = 4'h2;

    // Control code groups of the 5B stream
    localparam logic [4:0] PRXEC_SYM_IDLE = 5'h1f;
    localparam logic [4:0] PRXEC_SYM_J    = 5'h18;
    localparam logic [4:0] PRXEC_SYM_K    = 5'h11;
    localparam logic [4:0] PRXEC_SYM_T    = 5'h0d;
    localparam logic [4:0] PRXEC_SYM_R    = 5'h07;

    // Indicator route modes that carry the link stability flag
    localparam logic [1:0] PRXEC_ROUTE_MODE_A = 2'b10;
    localparam logic [1:0] PRXEC_ROUTE_MODE_B = 2'b01;

    // Timing
    localparam int PRXEC_CLK_MHZ        = 100;
    localparam int PRXEC_PKT_TIMEOUT_US = 722;
    localparam int PRXEC_LED_STRETCH_MS = 25;

    // Receive framing states
    typedef enum logic [1:0] {
        PRXEC_FR_IDLE = 2'b00,
        PRXEC_FR_JSEEN = 2'b01,
        PRXEC_FR_DATA = 2'b10,
        PRXEC_FR_TSEEN = 2'b11
    } prxec_frame_type;

    // Receive side of the media independent interface
    typedef struct packed {
        logic       dv;
        logic       er;
        logic [3:0] rxd;
    } prxec_mii_rx_type;
endpackage : prxec_pkg

// >>> rtl/prxec_top.sv
// Receive error code selection, bypass and status register logic of the 100 Mb/s coding sublayer
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/10ps

// Notes on behaviour
// - Read-only unstable link flag at bit four
// - Route modes 10/01 put flag on LED
// - Code error: RX_ER with 5h or 6h
// - Premature end: RX_ER with 4h or 6h
// - Two idles before T/R is premature end
// - Link error select: 3h with RX_ER, else pass
// - Packet time-out select: 2h with RX_ER
// - Loopback bit 15 reserved, reads zero
// - Bit 14 bypasses LED pulse stretching
// - Bit 13 loads from symbol strap at reset
// - Bit 13 skips both 4B5B code conversions
// - Monitor disable resets to inverted repeater strap
module prxec_top
    import prxec_pkg::*;
#(
    parameter int unsigned PKT_TO_CYC      = PRXEC_PKT_TIMEOUT_US * PRXEC_CLK_MHZ,
    parameter int unsigned LED_STRETCH_CYC = PRXEC_LED_STRETCH_MS * 1000 * PRXEC_CLK_MHZ
) (
    input  wire logic             ref_clk,
    input  wire logic             srst,
    input  wire logic [4:0]       reg_addr,
    input  wire logic [15:0]      reg_wdata,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    output logic [15:0]           reg_rdata,
    output logic                  irq,
    input  wire logic             sym_mode_strap,
    input  wire logic             repeater_select_strap,
    input  wire logic [1:0]       indicator_route_mode,
    input  wire logic             rx_sym_valid,
    input  wire logic [4:0]       rx_sym,
    input  wire logic             link_fail,
    input  wire logic             unstable_link_detect,
    input  wire logic [4:0]       tx_in,
    output logic [4:0]            tx_sym_out,
    input  wire logic             tx_activity,
    input  wire logic             rx_activity,
    output logic                  transmit_indicator_output,
    output logic                  receive_indicator_output,
    output prxec_mii_rx_type      mii_rx
);

    // Decode a 5B group: bit 4 of the result marks a valid data group
    function automatic logic [4:0] prxec_dec(input logic [4:0] s);
        case (s)
            5'h1e: prxec_dec = 5'h10;
            5'h09: prxec_dec = 5'h11;
            5'h14: prxec_dec = 5'h12;
            5'h15: prxec_dec = 5'h13;
            5'h0a: prxec_dec = 5'h14;
            5'h0b: prxec_dec = 5'h15;
            5'h0e: prxec_dec = 5'h16;
            5'h0f: prxec_dec = 5'h17;
            5'h12: prxec_dec = 5'h18;
            5'h13: prxec_dec = 5'h19;
            5'h16: prxec_dec = 5'h1a;
            5'h17: prxec_dec = 5'h1b;
            5'h1a: prxec_dec = 5'h1c;
            5'h1b: prxec_dec = 5'h1d;
            5'h1c: prxec_dec = 5'h1e;
            5'h1d: prxec_dec = 5'h1f;
            default: prxec_dec = 5'h00;
        endcase
    endfunction : prxec_dec

    // Encode a nibble into its 5B data group
    function automatic logic [4:0] prxec_enc(input logic [3:0] n);
        logic [4:0] tbl [16];
        tbl = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
                5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
        prxec_enc = tbl[n];
    endfunction : prxec_enc

    // Register state
    logic [3:0]        sel_ff, nxt_sel;            // Error code select bits 3..0
    logic              mon_dis_ff, nxt_mon_dis;    // Integrity monitor disable
    logic              unstable_ff, nxt_unstable;  // Unstable link flag
    logic              stretch_byp_ff, nxt_stretch_byp;
    logic              nib_byp_ff, nxt_nib_byp;
    logic [4:0]        irq_stat_ff, nxt_irq_stat;
    logic [4:0]        irq_mask_ff, nxt_irq_mask;
    logic [15:0]       rdata_ff, nxt_rdata;
    logic              irq_ff, nxt_irq;
    logic              link_fail_ff, nxt_link_fail; // For rising edge of link failure

    // Receive path state
    prxec_frame_type   frame_ff, nxt_frame;
    logic              idle_prev_ff, nxt_idle_prev; // Last group in frame was idle
    logic [16:0]       to_cnt_ff, nxt_to_cnt;       // Packet time-out counter
    prxec_mii_rx_type  rx_ff, nxt_rx;
    logic [4:0]        tx_sym_ff, nxt_tx_sym;

    // Indicator state
    logic [21:0]       led_cnt_ff [2];
    logic [21:0]       nxt_led_cnt [2];
    logic [1:0]        led_ff, nxt_led;

    // Receive events for interrupt status
    logic              ev_code, ev_pme, ev_pkt;

    // Receive framing, error substitution and transmit encoding
    always_comb begin
        logic [4:0] dec;
        logic       to_hit;
        dec           = prxec_dec(rx_sym);
        to_hit        = (to_cnt_ff == 17'(PKT_TO_CYC));
        nxt_frame     = frame_ff;
        nxt_idle_prev = idle_prev_ff;
        nxt_to_cnt    = to_cnt_ff;
        nxt_rx        = '{dv: 1'b0, er: 1'b0, rxd: 4'h0};
        ev_code       = 1'b0;
        ev_pme        = 1'b0;
        ev_pkt        = 1'b0;
        // Transmit: idle when not enabled, raw 5 bits when bypassed
        if (nib_byp_ff) begin
            nxt_tx_sym = tx_in;
        end else if (tx_in[4]) begin
            nxt_tx_sym = prxec_enc(tx_in[3:0]);
        end else begin
            nxt_tx_sym = PRXEC_SYM_IDLE;
        end
        if (nib_byp_ff) begin
            // Symbol mode: decoder skipped, group goes out on rxd and er
            nxt_frame = PRXEC_FR_IDLE;
            if (rx_sym_valid) begin
                nxt_rx = '{dv: 1'b1, er: rx_sym[4], rxd: rx_sym[3:0]};
            end
        end else if (rx_sym_valid) begin
            case (frame_ff)
                PRXEC_FR_IDLE: begin
                    if (rx_sym == PRXEC_SYM_J) begin
                        nxt_frame = PRXEC_FR_JSEEN;
                    end
                end
                PRXEC_FR_JSEEN: begin
                    // Start delimiter needs K right after J
                    nxt_frame     = (rx_sym == PRXEC_SYM_K) ? PRXEC_FR_DATA : PRXEC_FR_IDLE;
                    nxt_idle_prev = 1'b0;
                    nxt_to_cnt    = '0;
                end
                default: begin
                    // Inside a frame, including after T
                    nxt_rx.dv = 1'b1;
                    if (!to_hit) begin
                        nxt_to_cnt = to_cnt_ff + 17'h00001;
                    end
                    nxt_idle_prev = (rx_sym == PRXEC_SYM_IDLE);
                    if (rx_sym == PRXEC_SYM_IDLE && idle_prev_ff) begin
                        // Two idles before the end delimiter
                        ev_pme        = 1'b1;
                        nxt_rx.er     = 1'b1;
                        nxt_rx.rxd    = sel_ff[PRXEC_PME_SEL_BIT] ? PRXEC_NIB_PME_ALT : PRXEC_NIB_ERR_DEF;
                        nxt_frame     = PRXEC_FR_IDLE;
                    end else if (rx_sym == PRXEC_SYM_IDLE) begin
                        // First idle: hold data low, wait for the next group
                        nxt_rx.rxd = 4'h0;
                    end else if (frame_ff == PRXEC_FR_TSEEN && rx_sym == PRXEC_SYM_R) begin
                        nxt_rx.dv = 1'b0;
                        nxt_frame = PRXEC_FR_IDLE;
                    end else if (rx_sym == PRXEC_SYM_T && frame_ff == PRXEC_FR_DATA) begin
                        nxt_rx.dv = 1'b0;
                        nxt_frame = PRXEC_FR_TSEEN;
                    end else if (dec[4] && frame_ff == PRXEC_FR_DATA) begin
                        nxt_rx.rxd = dec[3:0];
                    end else begin
                        // Invalid group, or T not followed by R
                        ev_code    = 1'b1;
                        nxt_rx.er  = 1'b1;
                        nxt_rx.rxd = sel_ff[PRXEC_CODE_SEL_BIT] ? PRXEC_NIB_CODE_ALT : PRXEC_NIB_ERR_DEF;
                        nxt_frame  = PRXEC_FR_DATA;
                    end
                    // Time-out takes over the nibble once reached, unless the group ends the frame, if the packet time-out select bit is set
                    if (to_hit && nxt_frame != PRXEC_FR_IDLE) begin
                        ev_pkt = 1'b1;
                        if (sel_ff[PRXEC_PKT_SEL_BIT]) begin
                            nxt_rx.er  = 1'b1;
                            nxt_rx.rxd = PRXEC_NIB_PKT;
                        end
                    end
                end
            endcase
        end
        // Link failure has the highest priority when reporting is enabled
        if (link_fail && sel_ff[PRXEC_LINK_SEL_BIT]) begin
            nxt_rx.er  = 1'b1;
            nxt_rx.rxd = PRXEC_NIB_LINK;
        end
    end

    // Receive path registers
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            frame_ff     <= PRXEC_FR_IDLE;
            idle_prev_ff <= 1'b0;
            to_cnt_ff    <= '0;
            rx_ff        <= '0;
            tx_sym_ff    <= PRXEC_SYM_IDLE;
        end else begin
            frame_ff     <= nxt_frame;
            idle_prev_ff <= nxt_idle_prev;
            to_cnt_ff    <= nxt_to_cnt;
            rx_ff        <= nxt_rx;
            tx_sym_ff    <= nxt_tx_sym;
        end
    end

    // Indicator stretching and routing
    always_comb begin
        logic [1:0] ev;
        logic [1:0] shown;
        ev = {rx_activity, tx_activity};
        shown = 2'b00;
        for (int i = 0; i < 2; i++) begin
            // Reload on each event, count down to hold the indicator lit
            if (ev[i]) begin
                nxt_led_cnt[i] = 22'(LED_STRETCH_CYC);
            end else if (led_cnt_ff[i] != '0) begin
                nxt_led_cnt[i] = led_cnt_ff[i] - 22'h000001;
            end else begin
                nxt_led_cnt[i] = led_cnt_ff[i];
            end
            shown[i] = stretch_byp_ff ? ev[i] : (ev[i] | (led_cnt_ff[i] != '0));
        end
        nxt_led[1] = shown[1];
        if (indicator_route_mode == PRXEC_ROUTE_MODE_A || indicator_route_mode == PRXEC_ROUTE_MODE_B) begin
            nxt_led[0] = unstable_ff;
        end else begin
            nxt_led[0] = shown[0];
        end
    end

    // Indicator registers
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            led_cnt_ff[0] <= '0;
            led_cnt_ff[1] <= '0;
            led_ff        <= 2'h0;
        end else begin
            led_cnt_ff    <= nxt_led_cnt;
            led_ff        <= nxt_led;
        end
    end

    // Register writes, reads, status and interrupt
    always_comb begin
        logic [4:0] ev;
        logic [4:0] clr;
        nxt_sel         = sel_ff;
        nxt_mon_dis     = mon_dis_ff;
        nxt_stretch_byp = stretch_byp_ff;
        nxt_nib_byp     = nib_byp_ff;
        nxt_irq_mask    = irq_mask_ff;
        nxt_link_fail   = link_fail;
        nxt_rdata       = 16'h0000;
        clr             = 5'h00;
        // Flag follows the monitor only while it is enabled
        nxt_unstable    = unstable_link_detect & ~mon_dis_ff;
        if (reg_wr) begin
            if (reg_addr == PRXEC_PCS_CFG_ADDR) begin
                nxt_sel     = reg_wdata[3:0];
                nxt_mon_dis = reg_wdata[PRXEC_MON_DIS_BIT];
            end else if (reg_addr == PRXEC_LB_BYP_ADDR) begin
                // Bit 15 has no storage, so writes to it vanish
                nxt_stretch_byp = reg_wdata[PRXEC_STRETCH_BYP_BIT];
                nxt_nib_byp     = reg_wdata[PRXEC_NIB_BYP_BIT];
            end else if (reg_addr == PRXEC_IRQ_STAT_ADDR) begin
                clr = reg_wdata[4:0];
            end else if (reg_addr == PRXEC_IRQ_MASK_ADDR) begin
                nxt_irq_mask = reg_wdata[4:0];
            end
        end
        if (reg_rd) begin
            if (reg_addr == PRXEC_PCS_CFG_ADDR) begin
                nxt_rdata[3:0]                = sel_ff;
                nxt_rdata[PRXEC_UNSTABLE_BIT] = unstable_ff;
                nxt_rdata[PRXEC_MON_DIS_BIT]  = mon_dis_ff;
            end else if (reg_addr == PRXEC_LB_BYP_ADDR) begin
                nxt_rdata[PRXEC_LB_RSVD_BIT]     = 1'b0;
                nxt_rdata[PRXEC_STRETCH_BYP_BIT] = stretch_byp_ff;
                nxt_rdata[PRXEC_NIB_BYP_BIT]     = nib_byp_ff;
            end else if (reg_addr == PRXEC_IRQ_STAT_ADDR) begin
                nxt_rdata[4:0] = irq_stat_ff;
            end else if (reg_addr == PRXEC_IRQ_MASK_ADDR) begin
                nxt_rdata[4:0] = irq_mask_ff;
            end
        end
        ev = 5'h00;
        ev[PRXEC_IRQ_CODE_BIT] = ev_code;
        ev[PRXEC_IRQ_PME_BIT]  = ev_pme;
        ev[PRXEC_IRQ_LINK_BIT] = link_fail & ~link_fail_ff;
        ev[PRXEC_IRQ_PKT_BIT]  = ev_pkt;
        ev[PRXEC_IRQ_UNST_BIT] = nxt_unstable & ~unstable_ff;
        // A new event beats a clear in the same cycle
        nxt_irq_stat = (irq_stat_ff & ~clr) | ev;
        nxt_irq      = |(nxt_irq_stat & nxt_irq_mask);
    end

    // Register bank storage; straps are caught while reset is held
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            sel_ff         <= PRXEC_SEL_RST;
            mon_dis_ff     <= ~repeater_select_strap;
            unstable_ff    <= 1'b0;
            stretch_byp_ff <= PRXEC_STRETCH_BYP_RST;
            nib_byp_ff     <= sym_mode_strap;
            irq_stat_ff    <= PRXEC_IRQ_RST;
            irq_mask_ff    <= PRXEC_IRQ_RST;
            rdata_ff       <= PRXEC_RDATA_RST;
            irq_ff         <= 1'b0;
            link_fail_ff   <= 1'b0;
        end else begin
            sel_ff         <= nxt_sel;
            mon_dis_ff     <= nxt_mon_dis;
            unstable_ff    <= nxt_unstable;
            stretch_byp_ff <= nxt_stretch_byp;
            nib_byp_ff     <= nxt_nib_byp;
            irq_stat_ff    <= nxt_irq_stat;
            irq_mask_ff    <= nxt_irq_mask;
            rdata_ff       <= nxt_rdata;
            irq_ff         <= nxt_irq;
            link_fail_ff   <= nxt_link_fail;
        end
    end

    // Outputs straight from flip-flops
    assign reg_rdata                 = rdata_ff;
    assign irq                       = irq_ff;
    assign tx_sym_out                = tx_sym_ff;
    assign transmit_indicator_output = led_ff[0];
    assign receive_indicator_output  = led_ff[1];
    assign mii_rx                    = rx_ff;

endmodule : prxec_top
